// file: hw/rlc_remote_local.sv
// Purpose: remote/local state, addressing, bus command response, key gating
// Assumes: rx_byte/rx_stb come from acceptor handshake logic on clk_sys
// Notes: bus pins atn, ifc, ren and panel keys are asynchronous and synced here
`timescale 1ns/1ps
module rlc_remote_local (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic bus_atn,
   input wire logic bus_ifc,
   input wire logic bus_ren,
   input wire logic [7:0] rx_byte,
   input wire logic rx_stb,
   input wire logic [rlc_pkg::ADDR_W-1:0] my_addr,
   input wire logic key_local,
   input wire logic key_clear,
   input wire logic settled_trigger_code,
   input wire logic trig_mode_stb,
   input wire rlc_pkg::rlc_trig_e trig_mode_req,
   input wire logic setup_stb,
   input wire logic [rlc_pkg::FREQ_W-1:0] setup_freq,
   input wire logic [rlc_pkg::AMPL_W-1:0] setup_ampl,
   input wire rlc_pkg::rlc_meas_e setup_meas,
   input wire rlc_pkg::rlc_filt_e setup_filt,
   input wire logic srq_mask_stb,
   input wire logic [rlc_pkg::MASK_W-1:0] srq_mask_req,
   input wire logic cause_invalid,
   input wire logic cause_ready,
   input wire logic cause_error,
   input wire logic spoll_done,
   output logic srq_out,
   output logic srq_oe_n,
   output logic remote_ind,
   output logic addressed_ind,
   output logic listen_active,
   output logic talk_active,
   output logic spoll_active,
   output logic [rlc_pkg::STB_W-1:0] status_byte,
   output logic panel_keys_en,
   output logic local_key_en,
   output logic clear_key_en,
   output logic lockout,
   output logic entry_discard,
   output logic trigger_start,
   output logic dev_clear,
   output logic [rlc_pkg::FREQ_W-1:0] src_freq,
   output logic [rlc_pkg::AMPL_W-1:0] src_ampl,
   output rlc_pkg::rlc_meas_e meas_sel,
   output rlc_pkg::rlc_filt_e filt_sel,
   output rlc_pkg::rlc_trig_e trig_mode
);
   import rlc_pkg::*;

   localparam int SYN_W = 5;

   rlc_cmd_if cmd ();

   logic [SYN_W-1:0] sync1_r;
   logic [SYN_W-1:0] sync2_r;
   logic [SYN_W-1:0] sync_nxt;
   logic key_loc_d_r;
   logic key_clr_d_r;
   logic atn_s;
   logic ifc_s;
   logic ren_s;
   logic loc_press;
   logic clr_press;

   rlc_rl_e rl_r;
   rlc_rl_e rl_nxt;
   logic lockout_r;
   logic lockout_nxt;
   logic listen_r;
   logic listen_nxt;
   logic talk_r;
   logic talk_nxt;
   logic spoll_r;
   logic spoll_nxt;
   logic discard_r;
   logic discard_nxt;
   logic trig_r;
   logic trig_nxt;
   logic clr_r;
   logic clr_nxt;

   logic [STB_W-1:0] stb_r;
   logic [STB_W-1:0] stb_nxt;
   logic [MASK_W-1:0] mask_r;
   logic [MASK_W-1:0] mask_nxt;

   logic [FREQ_W-1:0] freq_r;
   logic [FREQ_W-1:0] freq_nxt;
   logic [AMPL_W-1:0] ampl_r;
   logic [AMPL_W-1:0] ampl_nxt;
   rlc_meas_e meas_r;
   rlc_meas_e meas_nxt;
   rlc_filt_e filt_r;
   rlc_filt_e filt_nxt;
   rlc_trig_e trig_mode_r;
   rlc_trig_e trig_mode_nxt;

   logic cmd_mode;
   logic do_clear;
   logic go_remote;
   logic go_local;
   logic want_srq;

   // two-flop synchronisers for pins; second stage is the only reader
   assign sync_nxt = {key_clear, key_local, bus_ren, bus_ifc, bus_atn};
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         key_loc_d_r <= 1'b0;
         key_clr_d_r <= 1'b0;
      end else begin
         sync1_r <= sync_nxt;
         sync2_r <= sync1_r;
         key_loc_d_r <= sync2_r[3];
         key_clr_d_r <= sync2_r[4];
      end
   end

   assign atn_s = sync2_r[0];
   assign ifc_s = sync2_r[1];
   assign ren_s = sync2_r[2];
   // rising edges of keys, one pulse per press
   assign loc_press = sync2_r[3] && !key_loc_d_r;
   assign clr_press = sync2_r[4] && !key_clr_d_r;

   // command decode only in command mode
   assign cmd_mode = atn_s && !ifc_s;
   assign cmd.cbyte = rx_byte;
   assign cmd.stb = rx_stb && cmd_mode;
   assign cmd.addr = my_addr;

   rlc_cmd_decode u_dec (
      .cmd (cmd.dec)
   );

   // device clear: universal always, selected only while listening
   assign do_clear = cmd.dcl || (cmd.sdc && listen_r);

   // remote entry needs ren true while own listen address arrives
   assign go_remote = (rl_r == RL_LOCAL) && ren_s && cmd.my_listen;

   // return to local: go-to-local while listening, or unlocked key press
   assign go_local = (rl_r == RL_REMOTE) &&
                     ((cmd.gtl && listen_r) ||
                      (loc_press && !lockout_r));

   // remote/local, lockout and addressing state
   always_comb begin
      rl_nxt = rl_r;
      lockout_nxt = lockout_r;
      listen_nxt = listen_r;
      talk_nxt = talk_r;
      spoll_nxt = spoll_r;
      discard_nxt = 1'b0;
      case (rl_r)
         RL_LOCAL: begin
            if (go_remote) begin
               rl_nxt = RL_REMOTE;
               discard_nxt = 1'b1;
            end
         end
         RL_REMOTE: begin
            if (go_local) begin
               rl_nxt = RL_LOCAL;
               discard_nxt = 1'b1;
            end
         end
         default: rl_nxt = RL_LOCAL;
      endcase
      // lockout may be set in either state
      if (cmd.llo) begin
         lockout_nxt = 1'b1;
      end
      if (do_clear) begin
         lockout_nxt = 1'b0;
      end
      // addressing; only primary addresses, secondaries ignored
      if (cmd.my_listen) begin
         listen_nxt = 1'b1;
      end else if (cmd.unl) begin
         listen_nxt = 1'b0;
      end
      if (cmd.my_talk) begin
         talk_nxt = 1'b1;
      end else if (cmd.unt || cmd.other_talk) begin
         talk_nxt = 1'b0;
      end
      if (cmd.spe) begin
         spoll_nxt = 1'b1;
      end else if (cmd.spd) begin
         spoll_nxt = 1'b0;
      end
      // pass control is decoded but deliberately has no effect
      if (cmd.tct) begin
         talk_nxt = talk_nxt;
      end
      // abort: unaddress and leave serial poll, remote state kept
      if (ifc_s) begin
         listen_nxt = 1'b0;
         talk_nxt = 1'b0;
         spoll_nxt = 1'b0;
      end
      // ren release overrides everything else
      if (!ren_s) begin
         if (rl_r == RL_REMOTE) begin
            discard_nxt = 1'b1;
         end
         rl_nxt = RL_LOCAL;
         lockout_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rl_r <= RL_LOCAL;
         lockout_r <= 1'b0;
         listen_r <= 1'b0;
         talk_r <= 1'b0;
         spoll_r <= 1'b0;
         discard_r <= 1'b0;
      end else begin
         rl_r <= rl_nxt;
         lockout_r <= lockout_nxt;
         listen_r <= listen_nxt;
         talk_r <= talk_nxt;
         spoll_r <= spoll_nxt;
         discard_r <= discard_nxt;
      end
   end

   // triggers and device clear pulses, plus instrument setup
   always_comb begin
      trig_nxt = 1'b0;
      clr_nxt = do_clear;
      freq_nxt = freq_r;
      ampl_nxt = ampl_r;
      meas_nxt = meas_r;
      filt_nxt = filt_r;
      trig_mode_nxt = trig_mode_r;
      // bus trigger and settled code need remote and listen
      if ((rl_r == RL_REMOTE) && listen_r && (cmd.get || settled_trigger_code)) begin
         trig_nxt = 1'b1;
      end
      // clear key acts as a manual trigger in remote unless locked out
      if ((rl_r == RL_REMOTE) && !lockout_r && clr_press) begin
         trig_nxt = 1'b1;
      end
      if (setup_stb) begin
         freq_nxt = setup_freq;
         ampl_nxt = setup_ampl;
         meas_nxt = setup_meas;
         filt_nxt = setup_filt;
      end
      if (trig_mode_stb) begin
         trig_mode_nxt = trig_mode_req;
      end
      // clear wins over a same-cycle setup write
      if (do_clear) begin
         freq_nxt = SRC_FREQ_CLR;
         ampl_nxt = SRC_AMPL_CLR;
         meas_nxt = MEAS_AC_LEVEL;
         filt_nxt = FILT_LP80K;
         trig_mode_nxt = TRIG_FREE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         trig_r <= 1'b0;
         clr_r <= 1'b0;
         freq_r <= SRC_FREQ_CLR;
         ampl_r <= SRC_AMPL_CLR;
         meas_r <= MEAS_AC_LEVEL;
         filt_r <= FILT_LP80K;
         trig_mode_r <= TRIG_FREE;
      end else begin
         trig_r <= trig_nxt;
         clr_r <= clr_nxt;
         freq_r <= freq_nxt;
         ampl_r <= ampl_nxt;
         meas_r <= meas_nxt;
         filt_r <= filt_nxt;
         trig_mode_r <= trig_mode_nxt;
      end
   end

   // status byte and service request; set beats every clear
   always_comb begin
      stb_nxt = stb_r;
      mask_nxt = mask_r;
      if (srq_mask_stb) begin
         mask_nxt = srq_mask_req;
      end
      if (do_clear) begin
         stb_nxt = STB_RESET;
         mask_nxt = SRQ_MASK_DEFAULT;
      end
      // rqs drops once the status byte has been polled out
      if (spoll_done) begin
         stb_nxt[STB_RQS_BIT] = 1'b0;
      end
      if (cause_ready) begin
         stb_nxt[STB_READY_BIT] = 1'b1;
      end
      if (cause_error) begin
         stb_nxt[STB_ERROR_BIT] = 1'b1;
      end
      if (cause_invalid) begin
         stb_nxt[STB_INVALID_BIT] = 1'b1;
      end
      // invalid code always requests, others only when enabled
      if (cause_invalid ||
          (cause_ready && mask_r[0]) ||
          (cause_error && mask_r[1])) begin
         stb_nxt[STB_RQS_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         stb_r <= STB_RESET;
         mask_r <= SRQ_MASK_DEFAULT;
      end else begin
         stb_r <= stb_nxt;
         mask_r <= mask_nxt;
      end
   end

   assign want_srq = stb_r[STB_RQS_BIT];

   // srq is open collector: pull low while a request stands
   assign srq_out = 1'b0;
   assign srq_oe_n = !want_srq;

   // indicators and talker/listener enables
   assign remote_ind = (rl_r == RL_REMOTE);
   assign addressed_ind = listen_r || talk_r;
   assign listen_active = listen_r;
   assign talk_active = talk_r && !spoll_r;
   assign spoll_active = talk_r && spoll_r;
   assign status_byte = stb_r;
   assign lockout = lockout_r;

   // key gating; lockout bites only once the unit is remote
   assign panel_keys_en = (rl_r == RL_LOCAL);
   assign local_key_en = (rl_r == RL_LOCAL) || !lockout_r;
   assign clear_key_en = (rl_r == RL_LOCAL) || !lockout_r;

   assign entry_discard = discard_r;
   assign trigger_start = trig_r;
   assign dev_clear = clr_r;
   assign src_freq = freq_r;
   assign src_ampl = ampl_r;
   assign meas_sel = meas_r;
   assign filt_sel = filt_r;
   // local forces free run without losing the programmed mode
   assign trig_mode = (rl_r == RL_LOCAL) ? TRIG_FREE : trig_mode_r;
endmodule // rlc_remote_local

// file: hw/rlc_pkg.sv
// Purpose: shared constants and types for the remote/local bus control block
// Assumes: 7-bit bus command codes, bit 7 of the data lines ignored
// Notes: status bit positions and mask layout are local conventions
package rlc_pkg;
   // universal and addressed bus commands (low seven bits)
   localparam logic [6:0] CMD_GTL = 7'h01;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_GET = 7'h08;
   localparam logic [6:0] CMD_TCT = 7'h09;
   localparam logic [6:0] CMD_LLO = 7'h11;
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_SPE = 7'h18;
   localparam logic [6:0] CMD_SPD = 7'h19;
   localparam logic [6:0] CMD_UNL = 7'h3f;
   localparam logic [6:0] CMD_UNT = 7'h5f;
   // address groups in bits 6:5
   localparam logic [1:0] GRP_LISTEN = 2'h1;
   localparam logic [1:0] GRP_TALK = 2'h2;
   localparam int ADDR_W = 5;
   // status byte layout
   localparam int STB_W = 8;
   localparam int STB_READY_BIT = 0;
   localparam int STB_ERROR_BIT = 1;
   localparam int STB_INVALID_BIT = 2;
   localparam int STB_RQS_BIT = 6;
   localparam logic [STB_W-1:0] STB_RESET = 8'h00;
   // service request enables: bit0 data ready, bit1 instrument error
   localparam int MASK_W = 2;
   localparam logic [MASK_W-1:0] SRQ_MASK_DEFAULT = 2'h0;
   // source presets applied by device clear
   localparam int FREQ_W = 20;
   localparam int AMPL_W = 16;
   localparam logic [FREQ_W-1:0] SRC_FREQ_CLR = 20'h003e8;
   localparam logic [AMPL_W-1:0] SRC_AMPL_CLR = 16'h0000;
   typedef enum logic [1:0] {MEAS_AC_LEVEL, MEAS_DISTN, MEAS_SINAD, MEAS_DC_LEVEL} rlc_meas_e;
   typedef enum logic [1:0] {FILT_NONE, FILT_LP30K, FILT_LP80K} rlc_filt_e;
   typedef enum logic [1:0] {TRIG_FREE, TRIG_HOLD, TRIG_IMMED, TRIG_SETTLED} rlc_trig_e;
   typedef enum logic {RL_LOCAL, RL_REMOTE} rlc_rl_e;
endpackage

// file: hw/rlc_cmd_if.sv
// Purpose: carries one command byte and its decoded meaning between modules
// Assumes: byte and strobe come from the acceptor handshake on clk_sys
// Notes: flags are only meaningful in the strobe cycle
`timescale 1ns/1ps
interface rlc_cmd_if;
   logic [7:0] cbyte;
   logic stb;
   logic [4:0] addr;
   logic my_listen;
   logic my_talk;
   logic other_talk;
   logic unl;
   logic unt;
   logic gtl;
   logic sdc;
   logic get;
   logic dcl;
   logic llo;
   logic spe;
   logic spd;
   logic tct;
   modport dec (input cbyte, stb, addr, output my_listen, my_talk, other_talk,
                unl, unt, gtl, sdc, get, dcl, llo, spe, spd, tct);
   modport ctl (output cbyte, stb, addr, input my_listen, my_talk, other_talk,
                unl, unt, gtl, sdc, get, dcl, llo, spe, spd, tct);
endinterface

// file: hw/rlc_cmd_decode.sv
// Purpose: turns a command-mode byte into one-hot command flags
// Assumes: caller gates stb with attention true and interface clear false
// Notes: secondary addresses are not recognised, no extended addressing
`timescale 1ns/1ps
module rlc_cmd_decode (
   rlc_cmd_if.dec cmd
);
   import rlc_pkg::*;

   logic [6:0] b;
   logic grp_l;
   logic grp_t;
   logic own;

   // parity bit dropped, address groups split by bits 6:5
   assign b = cmd.cbyte[6:0];
   assign grp_l = (b[6:5] == GRP_LISTEN) && (b != CMD_UNL);
   assign grp_t = (b[6:5] == GRP_TALK) && (b != CMD_UNT);
   assign own = (b[4:0] == cmd.addr);

   // flags qualified by the byte strobe
   assign cmd.my_listen = cmd.stb && grp_l && own;
   assign cmd.my_talk = cmd.stb && grp_t && own;
   assign cmd.other_talk = cmd.stb && grp_t && !own;
   assign cmd.unl = cmd.stb && (b == CMD_UNL);
   assign cmd.unt = cmd.stb && (b == CMD_UNT);
   assign cmd.gtl = cmd.stb && (b == CMD_GTL);
   assign cmd.sdc = cmd.stb && (b == CMD_SDC);
   assign cmd.get = cmd.stb && (b == CMD_GET);
   assign cmd.dcl = cmd.stb && (b == CMD_DCL);
   assign cmd.llo = cmd.stb && (b == CMD_LLO);
   assign cmd.spe = cmd.stb && (b == CMD_SPE);
   assign cmd.spd = cmd.stb && (b == CMD_SPD);
   assign cmd.tct = cmd.stb && (b == CMD_TCT);
endmodule // rlc_cmd_decode

// file: test/rlc_remote_local_sva.sv
// Purpose: port-level checks for the remote/local control block
// Assumes: single clock domain, synchronous active-low reset
// Notes: key enables are combinational, so checks use same-cycle relations
`timescale 1ns/1ps
module rlc_remote_local_sva (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic bus_ren,
   input wire logic remote_ind,
   input wire logic addressed_ind,
   input wire logic listen_active,
   input wire logic talk_active,
   input wire logic spoll_active,
   input wire logic panel_keys_en,
   input wire logic local_key_en,
   input wire logic clear_key_en,
   input wire logic lockout,
   input wire logic entry_discard,
   input wire logic trigger_start,
   input wire logic dev_clear,
   input wire logic [rlc_pkg::FREQ_W-1:0] src_freq,
   input wire logic [rlc_pkg::AMPL_W-1:0] src_ampl,
   input wire rlc_pkg::rlc_meas_e meas_sel,
   input wire rlc_pkg::rlc_filt_e filt_sel,
   input wire rlc_pkg::rlc_trig_e trig_mode
);
   import rlc_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // key gating against remote and lockout state
   chk_keys_remote: assert property (
      remote_ind |-> !panel_keys_en) else $error("panel keys live in remote");
   chk_keys_local: assert property (
      !remote_ind |-> panel_keys_en && local_key_en && clear_key_en)
      else $error("keys gated in local");
   chk_lockout_keys: assert property (
      remote_ind && lockout |-> !local_key_en && !clear_key_en)
      else $error("keys live under lockout");
   // remote entry lights both indicators and drops the entry
   chk_remote_entry: assert property (
      $rose(remote_ind) |-> addressed_ind && entry_discard)
      else $error("remote entry side effects missing");
   chk_addr_ind: assert property (
      addressed_ind == (listen_active || talk_active || spoll_active))
      else $error("addressed indicator wrong");
   chk_trig_free: assert property (
      !remote_ind |-> trig_mode == TRIG_FREE) else $error("trigger not free in local");
   // two sync flops plus one state edge, so four low samples suffice
   chk_ren_release: assert property (
      !bus_ren [*4] |=> !remote_ind && !lockout) else $error("ren release ignored");
   chk_clear_preset: assert property (
      dev_clear |-> src_freq == SRC_FREQ_CLR && src_ampl == SRC_AMPL_CLR &&
      meas_sel == MEAS_AC_LEVEL && filt_sel == FILT_LP80K && !lockout &&
      trig_mode == TRIG_FREE)
      else $error("device clear presets wrong");
   chk_trig_remote: assert property (
      trigger_start |-> $past(remote_ind)) else $error("trigger outside remote");
   cover property ($rose(remote_ind));
   cover property (remote_ind && lockout);
   cover property (dev_clear);
   cover property (trigger_start);
endmodule // rlc_remote_local_sva
bind rlc_remote_local rlc_remote_local_sva u_sva (.clk_sys, .nrst, .bus_ren, .remote_ind,
   .addressed_ind, .listen_active, .talk_active, .spoll_active, .panel_keys_en,
   .local_key_en, .clear_key_en, .lockout, .entry_discard, .trigger_start, .dev_clear,
   .src_freq, .src_ampl, .meas_sel, .filt_sel, .trig_mode);

// file: test/rlc_ctl_model.sv
// Purpose: behavioural bus controller driving pins and command bytes
// Assumes: acceptor handshake already reduced to byte plus strobe
// Notes: pins held steady long enough for the device synchronisers
`timescale 1ns/1ps
module rlc_ctl_model (
   input wire logic clk_sys,
   output logic bus_atn,
   output logic bus_ifc,
   output logic bus_ren,
   output logic [7:0] rx_byte,
   output logic rx_stb
);
   initial begin
      bus_atn = 1'b0;
      bus_ifc = 1'b0;
      bus_ren = 1'b0;
      rx_byte = 8'h00;
      rx_stb = 1'b0;
   end
   // one byte, attention settled first so the sync stage sees it
   task automatic send(input logic atn, input logic [7:0] b);
      @(posedge clk_sys) bus_atn <= atn;
      repeat (3) @(posedge clk_sys);
      rx_byte <= b;
      rx_stb <= 1'b1;
      @(posedge clk_sys) rx_stb <= 1'b0;
      rx_byte <= ~b; // released lines must not echo the old byte
      #1;
   endtask
   // ren and ifc set together, then held four edges for the synchronisers
   task automatic pin(input logic ren, input logic ifc);
      @(posedge clk_sys) bus_ren <= ren;
      bus_ifc <= ifc;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
endmodule // rlc_ctl_model

// file: test/tb_ieee488_remote_local_control.sv
// Purpose: scenario bench for the remote/local control block
// Assumes: controller model drives bus pins, bench drives parser side
// Notes: clear key trigger is judged at the edge its one-cycle pulse stands
`timescale 1ns/1ps
module tb_ieee488_remote_local_control;
   import rlc_pkg::*;
   localparam logic [4:0] MY = 5'h0b;
   localparam logic [7:0] LA = 8'h2b;
   localparam logic [7:0] TA = 8'h4b;
   logic clk_sys = 1'b0, nrst = 1'b0, bus_atn, bus_ifc, bus_ren, rx_stb;
   logic [7:0] rx_byte;
   logic [4:0] my_addr = MY;
   logic key_local = 1'b0, key_clear = 1'b0, settled_trigger_code = 1'b0;
   logic trig_mode_stb = 1'b0, setup_stb = 1'b0, srq_mask_stb = 1'b0;
   logic cause_invalid = 1'b0, cause_ready = 1'b0, cause_error = 1'b0, spoll_done = 1'b0;
   rlc_trig_e trig_mode_req = TRIG_FREE;
   logic [FREQ_W-1:0] setup_freq = 20'h00000;
   logic [AMPL_W-1:0] setup_ampl = 16'h0000;
   rlc_meas_e setup_meas = MEAS_AC_LEVEL;
   rlc_filt_e setup_filt = FILT_LP80K;
   logic [MASK_W-1:0] srq_mask_req = 2'h0;
   logic srq_out, srq_oe_n, remote_ind, addressed_ind, listen_active, talk_active;
   logic spoll_active, panel_keys_en, local_key_en, clear_key_en, lockout;
   logic entry_discard, trigger_start, dev_clear;
   logic [STB_W-1:0] status_byte;
   logic [FREQ_W-1:0] src_freq;
   logic [AMPL_W-1:0] src_ampl;
   rlc_meas_e meas_sel;
   rlc_filt_e filt_sel;
   rlc_trig_e trig_mode;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #2 clk_sys = ~clk_sys;
   rlc_ctl_model m (.clk_sys, .bus_atn, .bus_ifc, .bus_ren, .rx_byte, .rx_stb);
   rlc_remote_local uut (.clk_sys, .nrst, .bus_atn, .bus_ifc, .bus_ren, .rx_byte, .rx_stb,
      .my_addr, .key_local, .key_clear, .settled_trigger_code, .trig_mode_stb,
      .trig_mode_req, .setup_stb, .setup_freq, .setup_ampl, .setup_meas, .setup_filt,
      .srq_mask_stb, .srq_mask_req, .cause_invalid, .cause_ready, .cause_error,
      .spoll_done, .srq_out, .srq_oe_n, .remote_ind, .addressed_ind, .listen_active,
      .talk_active, .spoll_active, .status_byte, .panel_keys_en, .local_key_en,
      .clear_key_en, .lockout, .entry_discard, .trigger_start, .dev_clear, .src_freq,
      .src_ampl, .meas_sel, .filt_sel, .trig_mode);
   function automatic logic [7:0] c(input logic [6:0] x);
      return {1'b0, x};
   endfunction
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // key held well past sync plus edge detect
   task automatic press_local();
      @(posedge clk_sys) key_local <= 1'b1;
      repeat (6) @(posedge clk_sys);
      key_local <= 1'b0;
      #1;
   endtask
   // clear key: pulse lands three edges after the press, two sync plus the trigger register
   task automatic press_clear(input logic exp);
      @(posedge clk_sys) key_clear <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(trigger_start, exp);
      @(posedge clk_sys) key_clear <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_addressing();
      m.send(1'b0, LA);
      chk(listen_active, 1'b0);
      m.send(1'b1, LA);
      chk(addressed_ind, 1'b1);
      chk(remote_ind, 1'b0);
      m.send(1'b1, c(CMD_UNL));
      chk(addressed_ind, 1'b0);
   endtask
   task automatic t_remote();
      m.pin(1'b1, 1'b0);
      m.send(1'b1, LA);
      chk(remote_ind, 1'b1);
      chk(entry_discard, 1'b1);
      chk(panel_keys_en, 1'b0);
      chk(local_key_en, 1'b1);
      m.send(1'b1, c(CMD_GET));
      chk(trigger_start, 1'b1);
      press_clear(1'b1);
      @(posedge clk_sys) trig_mode_stb <= 1'b1;
      trig_mode_req <= TRIG_HOLD;
      @(posedge clk_sys) trig_mode_stb <= 1'b0;
      settled_trigger_code <= 1'b1;
      #1;
      chk(trig_mode, TRIG_HOLD);
      @(posedge clk_sys) settled_trigger_code <= 1'b0;
      #1;
      chk(trigger_start, 1'b1);
      press_local();
      chk(remote_ind, 1'b0);
      chk(trig_mode, TRIG_FREE);
   endtask
   task automatic t_lockout();
      m.send(1'b1, LA);
      m.send(1'b1, c(CMD_LLO));
      chk(local_key_en, 1'b0);
      press_local();
      chk(remote_ind, 1'b1);
      press_clear(1'b0);
      m.send(1'b1, c(CMD_GTL));
      chk(remote_ind, 1'b0);
      m.send(1'b1, LA);
      chk(remote_ind, 1'b1);
      m.pin(1'b0, 1'b0);
      chk(remote_ind, 1'b0);
      chk(lockout, 1'b0);
   endtask
   task automatic t_clear();
      @(posedge clk_sys) setup_stb <= 1'b1;
      setup_freq <= 20'h02710;
      setup_ampl <= 16'h0064;
      setup_meas <= MEAS_DISTN;
      setup_filt <= FILT_NONE;
      cause_invalid <= 1'b1;
      @(posedge clk_sys) setup_stb <= 1'b0;
      cause_invalid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(src_freq, 20'h02710);
      chk(srq_oe_n, 1'b0);
      m.pin(1'b1, 1'b0);
      m.send(1'b1, LA);
      chk(src_freq, 20'h02710);
      m.send(1'b1, c(CMD_SDC));
      chk(dev_clear, 1'b1);
      chk(status_byte, STB_RESET);
      chk(src_freq, SRC_FREQ_CLR);
      chk(src_ampl, SRC_AMPL_CLR);
      chk(meas_sel, MEAS_AC_LEVEL);
      chk(filt_sel, FILT_LP80K);
      chk(trig_mode, TRIG_FREE);
      @(posedge clk_sys) srq_mask_stb <= 1'b1;
      srq_mask_req <= 2'h1;
      @(posedge clk_sys) srq_mask_stb <= 1'b0;
      cause_ready <= 1'b1;
      @(posedge clk_sys) cause_ready <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(srq_oe_n, 1'b0);
      @(posedge clk_sys) spoll_done <= 1'b1;
      @(posedge clk_sys) spoll_done <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(srq_oe_n, 1'b1);
      // error cause requests service only once its enable is written
      @(posedge clk_sys) srq_mask_stb <= 1'b1;
      srq_mask_req <= 2'h2;
      @(posedge clk_sys) srq_mask_stb <= 1'b0;
      cause_error <= 1'b1;
      @(posedge clk_sys) cause_error <= 1'b0;
      #1;
      chk(srq_oe_n, 1'b0);
      chk(status_byte[STB_ERROR_BIT], 1'b1);
      m.send(1'b1, c(CMD_UNL));
      m.send(1'b1, c(CMD_DCL));
      chk(dev_clear, 1'b1);
      chk(srq_oe_n, 1'b1);
      @(posedge clk_sys) cause_ready <= 1'b1;
      @(posedge clk_sys) cause_ready <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(srq_oe_n, 1'b1);
      m.send(1'b1, c(CMD_SDC));
      chk(dev_clear, 1'b0);
   endtask
   task automatic t_talk();
      m.send(1'b1, TA);
      chk(talk_active, 1'b1);
      m.send(1'b1, c(CMD_TCT));
      chk(talk_active, 1'b1);
      m.send(1'b1, c(CMD_SPE));
      chk(spoll_active, 1'b1);
      m.pin(1'b1, 1'b1);
      chk(addressed_ind, 1'b0);
      m.send(1'b1, TA);
      chk(talk_active, 1'b0);
      m.pin(1'b1, 1'b0);
   endtask
   // hang guard, full run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         $display("ERROR %0t run did not finish", $time);
         test_done();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(remote_ind, 1'b0);
      chk(lockout, 1'b0);
      chk(srq_oe_n, 1'b1);
      chk(srq_out, 1'b0);
      t_addressing();
      t_remote();
      t_lockout();
      t_clear();
      t_talk();
      test_done();
   end
endmodule // tb_ieee488_remote_local_control
